/* File: rtl/rst_seq_cfg.svh */
// Purpose: constants for the reset sequencer
// Assumes: 250 MHz core clock
// Notes: counts in system clock pulses
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH
`define STARTUP_PULSES 1024
`define STARTUP_CW 11
`define PC_RESET_VAL 17'h00000
`define SP_RESET_VAL 3'h0
`define WDSEL_RESET_VAL 8'h07
`define PORT_RESET_VAL 8'hff
`define TMRC_RESET_VAL 8'h08
`define INTC_RESET_VAL 8'h00
`endif

/* File: rtl/rst_seq_pkg.sv */
// Purpose: types for the reset sequencer
// Assumes: nothing
// Notes: state codes Gray ordered run, hold, delay, halt; delay to run flips both bits
package rst_seq_pkg;
   typedef enum logic [1:0] {
      st_run_type = 2'b00,
      st_hold_type = 2'b01,
      st_delay_type = 2'b11,
      st_halt_type = 2'b10
   } seq_state_type;
   typedef enum logic [1:0] {
      cause_none_type = 2'h0,
      cause_full_type = 2'h1,
      cause_warm_type = 2'h2
   } reset_kind_type;
endpackage

/* File: rtl/startup_delay_timer.sv */
// Purpose: counts the oscillator start-up delay
// Assumes: start pulse restarts the count
// Notes: done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_cfg.svh"
module startup_delay_timer (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic start,
   output logic busy,
   output logic done
);
   logic [`STARTUP_CW-1:0] cnt_q;
   logic busy_q;
   logic done_q;
   wire last = (cnt_q == `STARTUP_CW'(`STARTUP_PULSES - 1));
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || start)
      begin
         cnt_q <= '0;
         busy_q <= start;
         done_q <= 1'b0;
      end
      else if (busy_q)
      begin
         cnt_q <= cnt_q + `STARTUP_CW'(1);
         busy_q <= !last;
         done_q <= last;
      end
      else
         done_q <= 1'b0;
   end
   assign busy = busy_q;
   assign done = done_q;
endmodule // startup_delay_timer
`default_nettype wire

/* File: rtl/mcu_reset_sequencer.sv */
// Purpose: reset cause capture, start-up delay and reset outputs
// Assumes: halt_exec and wdt_clear_exec are core pulses, wdt_overflow a pulse
// Notes: reset outputs active high and registered
`timescale 1ns/1ps
`default_nettype none
`include "rst_seq_cfg.svh"
module mcu_reset_sequencer
   import rst_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ext_reset_pin_n,
   input wire logic wdt_overflow,
   input wire logic halt_exec,
   input wire logic wdt_clear_exec,
   input wire logic wake_event,
   output logic core_hold,
   output logic chip_reset,
   output logic warm_reset,
   output logic wdt_clear,
   output logic watchdog_timeout_flag,
   output logic powerdown_flag,
   output logic osc_enable,
   output logic [16:0] pc_reset_value,
   output logic [2:0] sp_reset_value,
   output logic [7:0] watchdog_select_reg_init,
   output logic [7:0] port_data_init,
   output logic [7:0] port_ctrl_init,
   output logic [7:0] timer_ctrl_init,
   output logic [7:0] intc_init
);
   import rst_seq_pkg::*;

   logic pin_s1_q;
   logic pin_s2_q;
   logic pin_prev_q;
   seq_state_type state_q;
   seq_state_type state_d;
   logic timeout_q;
   logic pdf_q;
   logic hold_q;
   logic chip_q;
   logic warm_q;
   logic wdc_q;
   logic sst_start;
   logic sst_busy;
   logic sst_done;
   logic sys_rst_pulse_q;
   logic rst_seen_q;

   // Pin passes two flops before use; stage one is read by stage two only
   always_ff @(posedge core_clk)
   begin
      pin_s1_q <= ext_reset_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
   end

   wire pin_low = !pin_s2_q;
   wire pin_release = pin_s2_q && !pin_prev_q;
   wire in_run = (state_q == st_run_type);
   wire in_halt = (state_q == st_halt_type);
   wire pin_run = pin_low && in_run;
   wire pin_halt = pin_low && in_halt;
   wire wdt_run = wdt_overflow && in_run && !pin_low;
   wire wdt_halt = wdt_overflow && in_halt && !pin_low;
   // Wake from halt by a non-reset source also counts as a wake
   wire wake_soft = wake_event && in_halt && !pin_low && !wdt_overflow;
   wire full_req = pin_run || pin_halt || wdt_run;

   // Start-up delay on power-up, any halt wake, and pin release while pdf_q is set; none for pin reset with pdf_q clear
   assign sst_start = sys_rst ? 1'b0 :
      ((state_q == st_hold_type) && pin_release && pdf_q) || wdt_halt || wake_soft;

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         st_run_type:
         begin
            if (pin_run)
               state_d = st_hold_type;
            else if (halt_exec && !wdt_run)
               state_d = st_halt_type;
         end
         st_halt_type:
         begin
            if (pin_halt)
               state_d = st_hold_type;
            else if (wdt_halt || wake_soft)
               state_d = st_delay_type;
         end
         st_hold_type:
         begin
            // Pin release waits the delay while pdf_q is set, as after a halt wake by pin; with pdf_q clear it goes straight to run
            if (pin_release)
               state_d = pdf_q ? st_delay_type : st_run_type;
         end
         st_delay_type:
         begin
            if (pin_low)
               state_d = st_hold_type;
            else if (sst_done)
               state_d = st_run_type;
         end
         default: state_d = st_hold_type;
      endcase
   end

   startup_delay_timer u_sst (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .start(sst_start | sys_rst_pulse_q),
      .busy(sst_busy),
      .done(sst_done)
   );

   // Power-up start of the delay, one cycle after reset release
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         rst_seen_q <= 1'b1;
         sys_rst_pulse_q <= 1'b0;
      end
      else
      begin
         rst_seen_q <= 1'b0;
         sys_rst_pulse_q <= rst_seen_q;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         state_q <= st_delay_type;
      else
         state_q <= state_d;
   end

   // Status flags; event set wins over clear in same cycle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         timeout_q <= 1'b0;
         pdf_q <= 1'b0;
      end
      else
      begin
         if (wdt_run || wdt_halt)
            timeout_q <= 1'b1;
         else if (pin_halt || (halt_exec && in_run))
            timeout_q <= 1'b0;
         if (halt_exec && in_run && !full_req)
            pdf_q <= 1'b1;
         else if (wdt_halt || pin_halt)
            pdf_q <= 1'b1;
         else if (wdt_clear_exec && in_run)
            pdf_q <= 1'b0;
      end
   end

   wire hold_d = (state_d != st_run_type) && (state_d != st_halt_type);
   wire chip_d = (state_d == st_hold_type) || full_req;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         hold_q <= 1'b1;
         chip_q <= 1'b1;
         warm_q <= 1'b0;
         wdc_q <= 1'b1;
      end
      else
      begin
         hold_q <= hold_d || sst_busy;
         chip_q <= chip_d;
         warm_q <= wdt_halt;
         // Watchdog held clear while chip reset asserted, and for one cycle on halt entry from run
         wdc_q <= chip_d || (halt_exec && in_run);
      end
   end

   assign core_hold = hold_q;
   assign chip_reset = chip_q;
   assign warm_reset = warm_q;
   assign wdt_clear = wdc_q;
   assign watchdog_timeout_flag = timeout_q;
   assign powerdown_flag = pdf_q;
   // Oscillator stays stopped in halt
   logic osc_q;
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         osc_q <= 1'b1;
      else
         osc_q <= (state_d != st_halt_type);
   end
   assign osc_enable = osc_q;
   // Reset values; constant flops so every output is registered
   logic [16:0] pc_q;
   logic [2:0] sp_q;
   logic [7:0] wds_q;
   logic [7:0] pd_q;
   logic [7:0] pc8_q;
   logic [7:0] tc_q;
   logic [7:0] ic_q;
   always_ff @(posedge core_clk)
   begin
      pc_q <= `PC_RESET_VAL;
      sp_q <= `SP_RESET_VAL;
      wds_q <= `WDSEL_RESET_VAL;
      pd_q <= `PORT_RESET_VAL;
      pc8_q <= `PORT_RESET_VAL;
      tc_q <= `TMRC_RESET_VAL;
      ic_q <= `INTC_RESET_VAL;
   end
   assign pc_reset_value = pc_q;
   assign sp_reset_value = sp_q;
   assign watchdog_select_reg_init = wds_q;
   assign port_data_init = pd_q;
   assign port_ctrl_init = pc8_q;
   assign timer_ctrl_init = tc_q;
   assign intc_init = ic_q;
endmodule // mcu_reset_sequencer
`default_nettype wire

/* File: bench/rst_seq_monitor.sv */
// Purpose: port checks for the reset sequencer
// Assumes: one clock, synchronous reset
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module rst_seq_monitor (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic ext_reset_pin_n,
   input wire logic wdt_overflow,
   input wire logic halt_exec,
   input wire logic core_hold,
   input wire logic chip_reset,
   input wire logic warm_reset,
   input wire logic wdt_clear,
   input wire logic watchdog_timeout_flag,
   input wire logic powerdown_flag,
   input wire logic osc_enable
);
   logic [11:0] hold_q;
   logic woke_q;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Saturates so a stuck hold cannot wrap
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || !core_hold) hold_q <= 12'h000;
      else if (!hold_q[11]) hold_q <= hold_q + 12'h001;
      if (sys_rst || !osc_enable) woke_q <= 1'b1;
      else if (!core_hold) woke_q <= 1'b0;
   end
   sequence s_pin_low;
      !ext_reset_pin_n [*3];
   endsequence
   sequence s_fast_release;
      core_hold [*2] ##[1:4] !core_hold;
   endsequence
   property p_pin_reset;
      s_pin_low |=> chip_reset && wdt_clear && core_hold;
   endproperty
   a_pin_reset: assert property (p_pin_reset) else $error("pin reset missing");
   property p_pin_release;
      $rose(ext_reset_pin_n) && chip_reset && osc_enable && !powerdown_flag |-> s_fast_release;
   endproperty
   a_pin_release: assert property (p_pin_release) else $error("pin release");
   property p_wdt_run;
      wdt_overflow && !core_hold && osc_enable && ext_reset_pin_n
         |=> chip_reset && watchdog_timeout_flag && powerdown_flag == $past(powerdown_flag);
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("watchdog run reset");
   property p_wdt_halt;
      wdt_overflow && !osc_enable && ext_reset_pin_n
         |=> warm_reset && !chip_reset && watchdog_timeout_flag && powerdown_flag;
   endproperty
   a_wdt_halt: assert property (p_wdt_halt) else $error("warm reset");
   property p_warm_once;
      warm_reset |=> !warm_reset && core_hold;
   endproperty
   a_warm_once: assert property (p_warm_once) else $error("warm pulse");
   property p_halt_in;
      halt_exec && !core_hold && osc_enable |=> powerdown_flag && !watchdog_timeout_flag;
   endproperty
   a_halt_in: assert property (p_halt_in) else $error("halt flags");
   property p_delay;
      $fell(core_hold) && woke_q |-> hold_q >= 12'h3ff;
   endproperty
   a_delay: assert property (p_delay) else $error("delay short");
   property p_cause;
      $rose(chip_reset) |-> !$past(ext_reset_pin_n, 3) || $past(wdt_overflow);
   endproperty
   a_cause: assert property (p_cause) else $error("reset cause");
endmodule // rst_seq_monitor
bind mcu_reset_sequencer rst_seq_monitor MON (.*);
`default_nettype wire

/* File: bench/pin_wdt_model.sv */
// Purpose: reset pin and watchdog overflow source
// Assumes: changes 1 ns after the edge
// Notes: pin idles high, overflow one cycle
`timescale 1ns/1ps
`default_nettype none
module pin_wdt_model (
   input wire logic core_clk,
   output logic ext_reset_pin_n,
   output logic wdt_overflow
);
   initial
   begin
      ext_reset_pin_n = 1'b1;
      wdt_overflow = 1'b0;
   end
   // Low level asks for reset
   task automatic pin_reset(input int n);
      @(posedge core_clk) #1 ext_reset_pin_n = 1'b0;
      repeat (n) @(posedge core_clk);
      #1 ext_reset_pin_n = 1'b1;
   endtask
   task automatic wdt_pulse();
      @(posedge core_clk) #1 wdt_overflow = 1'b1;
      @(posedge core_clk) #1 wdt_overflow = 1'b0;
   endtask
endmodule // pin_wdt_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: self-checking bench for the reset sequencer
// Assumes: inputs change 1 ns after the edge
// Notes: rows hold an event and the flags it leaves
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic core_clk, sys_rst, halt_exec, wdt_clear_exec, wake_event;
   logic ext_reset_pin_n, wdt_overflow, core_hold, chip_reset, warm_reset, wdt_clear;
   logic watchdog_timeout_flag, powerdown_flag, osc_enable;
   logic [16:0] pc_reset_value;
   logic [2:0] sp_reset_value;
   logic [7:0] watchdog_select_reg_init, port_data_init, port_ctrl_init;
   logic [7:0] timer_ctrl_init, intc_init;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   int hold_n;
   typedef struct {int op; logic [1:0] flags; logic long_d;} row_type;
   row_type rows [7];
   mcu_reset_sequencer DUT (.*);
   pin_wdt_model PART (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Ceiling well above the longest path
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic pulse(input bit w);
      @(posedge core_clk) #1;
      wake_event = w;
      wdt_clear_exec = !w;
      halt_exec = 1'b0;
      @(posedge core_clk) #1;
      wake_event = 1'b0;
      wdt_clear_exec = 1'b0;
   endtask
   task automatic settle();
      hold_n = 0;
      repeat (3) @(posedge core_clk);
      #1;
      while (core_hold !== 1'b0 && hold_n < 3000)
         @(posedge core_clk) #1 hold_n++;
   endtask
   // Window check also fails a hold that never drops
   task automatic power_reset();
      sys_rst = 1'b1;
      repeat (4) @(posedge core_clk);
      #1;
      cmp(32'({chip_reset, wdt_clear, warm_reset, core_hold, osc_enable}), 32'h1b);
      cmp(32'({watchdog_timeout_flag, powerdown_flag}), 32'h0);
      sys_rst = 1'b0;
      settle();
      cmp(32'({watchdog_timeout_flag, powerdown_flag}), 32'h0);
      cmp(32'(hold_n inside {[1000:1100]}), 32'h1);
   endtask
   task automatic run_op(input int op);
      if (op inside {[2:4]})
      begin
         @(posedge core_clk) #1 halt_exec = 1'b1;
         @(posedge core_clk) #1 halt_exec = 1'b0;
         repeat (4) @(posedge core_clk);
         #1;
         cmp(32'({osc_enable, powerdown_flag, core_hold}), 32'h2);
      end
      case (op)
         0, 2: PART.pin_reset(6);
         1, 3: PART.wdt_pulse();
         4: pulse(1'b1);
         default: pulse(1'b0);
      endcase
   endtask
   initial
   begin
      halt_exec = 1'b0;
      wdt_clear_exec = 1'b0;
      wake_event = 1'b0;
      rows = '{'{1, 2'b10, 0}, '{0, 2'b10, 0}, '{2, 2'b01, 1}, '{3, 2'b11, 1},
               '{4, 2'b01, 1}, '{5, 2'b00, 0}, '{0, 2'b00, 0}};
      power_reset();
      cmp(32'({pc_reset_value, sp_reset_value}), 32'h0);
      cmp(32'({timer_ctrl_init, intc_init}), 32'h0800);
      cmp(32'({watchdog_select_reg_init, port_data_init, port_ctrl_init}), 32'h07ffff);
      foreach (rows[i])
      begin
         run_op(rows[i].op);
         settle();
         cmp(32'({watchdog_timeout_flag, powerdown_flag}), 32'(rows[i].flags));
         cmp(32'(hold_n inside {[1000:1100]}), 32'(rows[i].long_d));
      end
      fork
         PART.pin_reset(8);
         #20 PART.wdt_pulse();
      join
      settle();
      cmp(32'({watchdog_timeout_flag, powerdown_flag}), 32'h0);
      // Second power-on reset in mid-run must clear a set timeout flag
      PART.wdt_pulse();
      cmp(32'({watchdog_timeout_flag, powerdown_flag}), 32'h2);
      power_reset();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
